// File: design/nvr_rtc_sram.sv
/*
 Byte-wide nonvolatile SRAM with a BCD clock in its eight top bytes,
 behind asynchronous SRAM strobes. Assumes pins are asynchronous to clk
 and that a supply comparator reports the power-fail condition.
*/
// Function
// R1 - setting the read bit freezes the visible clock bytes while it stays set
// R2 - internal counters keep running while the visible copy is halted
// R3 - clearing the halt refreshes all visible bytes together within a second
// R4 - setting the write bit halts visible updates so bytes can be loaded
// R5 - clearing the write bit loads the counters from the visible bytes
// R6 - host loads day, date and time in BCD, 24-hour form
// R7 - seconds top bit set stops the oscillator, at any time
// R8 - frequency test bit makes seconds LSB toggle at 512 Hz
// R9 - a live read of seconds shows the 512 Hz toggle on data line zero
// R10 - host writes zero into every unused clock bit
// R11 - write enable high with chip select low is read mode
// R12 - data pins driven only when chip select and output enable are low
// R13 - on address change old data holds briefly, then new data follows
// R14 - write mode when write enable and chip select are both low
// R15 - host keeps the address stable through a write
// R16 - host keeps a strobe inactive for the recovery time between cycles
// R17 - host keeps output enable high during writes or avoids contention
// R18 - output driven before write enable falls stops shortly after it falls
// R19 - below the power-fail threshold all access is blocked
// R20 - power-fail output is low while the supply is below threshold
// R21 - on battery the RAM, clock bytes and counting are preserved
// R22 - 32768 bytes, clock in the top eight, RAM below
// R23 - date rolls over by month length and leap year
// R24 - each field counts in BCD within its range
// R25 - unused clock bits read as zero
`timescale 1ns/1ps
`default_nettype none
module nvr_rtc_sram #(
   parameter int CLK_HZ      = nvr_pkg::CLK_HZ,
   parameter int TICK_CYCLES = CLK_HZ / nvr_pkg::TICK_HZ
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [14:0] addr,
   input  wire logic [7:0]  dq_in,
   output logic [7:0]       dq_out,
   output logic             dq_oe_n,
   input  wire logic        supply_below_pf,
   output logic             power_fail_out_n
);
   localparam int DIV_W = $clog2(TICK_CYCLES);
   localparam int SUB_W = $clog2(nvr_pkg::TICK_HZ);

   logic [26:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
   logic [DIV_W-1:0] div_reg, div_next;
   logic [SUB_W-1:0] sub_reg, sub_next;
   logic             phase_reg, phase_next;
   logic             ctl_write_reg, ctl_write_next, ctl_read_reg, ctl_read_next;
   logic             osc_stop_reg, osc_stop_next, ft_reg, ft_next;
   logic [7:0]       vis_reg [1:7];
   logic [7:0]       vis_next [1:7];
   logic [7:0]       cnt [1:7];
   logic             wr_act_reg, wr_act_next;
   logic [14:0]      wr_addr_reg, wr_addr_next, prev_addr_reg;
   logic [7:0]       wr_data_reg, wr_data_next, dq_out_reg, dq_out_next, rd_sel;
   logic [1:0]       hold_reg, hold_next;
   logic             oe_n_reg, oe_n_next, pfo_reg, pfo_next;
   logic             pf_f, ce_f, oe_f, we_f, tick, sec_tick, halted, commit, mem_we, cnt_load, read_en;
   logic [14:0]      addr_f;
   logic [7:0]       dq_f;
   logic [7:0]       mem [0:32767];

   assign {pf_f, ce_f, oe_f, we_f, addr_f, dq_f} = filt_reg;
   assign halted = ctl_write_reg | ctl_read_reg;

   nvr_time_counter u_cnt (
      .clk      (clk),
      .rst_n    (rst_n),
      .sec_tick (sec_tick),
      .load     (cnt_load),
      .ld_sec   (vis_reg[1]),
      .ld_min   (vis_reg[2]),
      .ld_hr    (vis_reg[3]),
      .ld_day   (vis_reg[4]),
      .ld_date  (vis_reg[5]),
      .ld_mon   (vis_reg[6]),
      .ld_year  (vis_reg[7]),
      .cnt_sec  (cnt[1]),
      .cnt_min  (cnt[2]),
      .cnt_hr   (cnt[3]),
      .cnt_day  (cnt[4]),
      .cnt_date (cnt[5]),
      .cnt_mon  (cnt[6]),
      .cnt_year (cnt[7])
   );

   // read mux: RAM below the clock block, masked clock bytes above
   always_comb begin
      rd_sel = mem[addr_f];
      if (addr_f >= nvr_pkg::ADDR_CTL) begin // R22
         unique case (addr_f)
            nvr_pkg::ADDR_CTL: rd_sel = {ctl_write_reg, ctl_read_reg, 6'h00}; // R25
            nvr_pkg::ADDR_SEC: begin // R9
               rd_sel = {osc_stop_reg, vis_reg[1][6:0]};
               if (ft_reg && !osc_stop_reg) rd_sel[0] = phase_reg;
            end
            nvr_pkg::ADDR_DAY: rd_sel = {1'b0, ft_reg, 3'h0, vis_reg[4][2:0]}; // R25
            default: rd_sel = vis_reg[addr_f[2:0]] & nvr_pkg::field_mask(addr_f[2:0]);
         endcase
      end
   end

   always_comb begin
      // only s2 and s3 feed the agreement filter
      filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
      tick = !osc_stop_reg && div_reg == DIV_W'(TICK_CYCLES - 1); // R7
      div_next = osc_stop_reg ? div_reg : (tick ? '0 : div_reg + DIV_W'(1));
      sub_next = tick ? sub_reg + SUB_W'(1) : sub_reg;
      sec_tick = tick && sub_reg == SUB_W'(nvr_pkg::TICK_HZ - 1); // R2
      phase_next = tick ? !phase_reg : phase_reg; // R8
      // pf_f gates chip select for both modes
      wr_act_next = !ce_f && !we_f && !pf_f; // R14 R19
      wr_addr_next = wr_act_next ? addr_f : wr_addr_reg;
      wr_data_next = wr_act_next ? dq_f : wr_data_reg;
      // byte commits at end of write; a write cut by power fail is dropped
      commit = wr_act_reg && !wr_act_next && !pf_f; // R14 R19
      mem_we = commit && wr_addr_reg < nvr_pkg::ADDR_CTL;
      ctl_write_next = ctl_write_reg;
      ctl_read_next = ctl_read_reg;
      osc_stop_next = osc_stop_reg;
      ft_next = ft_reg;
      vis_next = vis_reg;
      if (!halted) begin // R3
         for (int i = 1; i <= 7; i++) begin
            vis_next[i] = cnt[i];
         end
      end
      if (commit && wr_addr_reg >= nvr_pkg::ADDR_CTL) begin
         if (wr_addr_reg == nvr_pkg::ADDR_CTL) begin
            ctl_write_next = wr_data_reg[nvr_pkg::CTL_WRITE_BIT]; // R4
            ctl_read_next = wr_data_reg[nvr_pkg::CTL_READ_BIT]; // R1
         end else begin
            if (wr_addr_reg == nvr_pkg::ADDR_SEC) osc_stop_next = wr_data_reg[nvr_pkg::SEC_OSC_BIT]; // R7
            if (wr_addr_reg == nvr_pkg::ADDR_DAY) ft_next = wr_data_reg[nvr_pkg::DAY_FT_BIT]; // R8
            // time fields only land while the write bit holds the copy
            if (ctl_write_reg) begin // R4
               vis_next[wr_addr_reg[2:0]] = wr_data_reg & nvr_pkg::field_mask(wr_addr_reg[2:0]);
            end
         end
      end
      cnt_load = ctl_write_reg && !ctl_write_next; // R5
      read_en = !ce_f && we_f && !oe_f && !pf_f; // R11 R12 R18
      oe_n_next = !read_en;
      // old data stays a short while after an address change
      if (addr_f != prev_addr_reg) begin // R13
         hold_next = 2'(nvr_pkg::OUT_HOLD_CYC);
         dq_out_next = dq_out_reg;
      end else if (hold_reg != 2'h0) begin
         hold_next = hold_reg - 2'h1;
         dq_out_next = dq_out_reg;
      end else begin
         hold_next = 2'h0;
         dq_out_next = rd_sel; // R9
      end
      pfo_next = !pf_f; // R20
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         {s1_reg, s2_reg, s3_reg, filt_reg} <= {4{nvr_pkg::SYNC_RST}};
         div_reg <= '0;
         sub_reg <= '0;
         {phase_reg, ctl_write_reg, ctl_read_reg, osc_stop_reg, ft_reg} <= 5'h00;
         for (int i = 1; i <= 7; i++) begin
            vis_reg[i] <= 8'h00;
         end
         {wr_act_reg, wr_addr_reg, wr_data_reg} <= 24'h000000;
         {prev_addr_reg, dq_out_reg, hold_reg} <= 25'h0000000;
         {oe_n_reg, pfo_reg} <= 2'h3;
      end else begin
         s1_reg <= {supply_below_pf, ce_n, oe_n, we_n, addr, dq_in};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= filt_next;
         div_reg <= div_next;
         sub_reg <= sub_next;
         {phase_reg, ctl_write_reg, ctl_read_reg} <= {phase_next, ctl_write_next, ctl_read_next};
         {osc_stop_reg, ft_reg} <= {osc_stop_next, ft_next};
         vis_reg <= vis_next;
         {wr_act_reg, wr_addr_reg, wr_data_reg} <= {wr_act_next, wr_addr_next, wr_data_next};
         {prev_addr_reg, dq_out_reg, hold_reg} <= {addr_f, dq_out_next, hold_next};
         {oe_n_reg, pfo_reg} <= {oe_n_next, pfo_next};
      end
   end

   // SRAM array: no reset, contents survive like a retained store
   always_ff @(posedge clk) begin
      if (mem_we) mem[wr_addr_reg] <= wr_data_reg;
   end

   assign dq_out = dq_out_reg;
   assign dq_oe_n = oe_n_reg;
   assign power_fail_out_n = pfo_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_freeze;
      ctl_read_reg && $past(ctl_read_reg) && !$past(commit) |-> $stable(vis_reg[nvr_pkg::IDX_SEC]);
   endproperty
   a_freeze: assert property (p_freeze) else $error("visible seconds moved while frozen"); // R1

   property p_count_on;
      halted && sec_tick && !cnt_load |=> cnt[1] != $past(cnt[1]);
   endproperty
   a_count_on: assert property (p_count_on) else $error("internal seconds stopped while halted"); // R2

   sequence s_release;
      halted ##1 !halted;
   endsequence
   property p_refresh;
      s_release |=> vis_reg[nvr_pkg::IDX_SEC] == $past(cnt[1]) && vis_reg[nvr_pkg::IDX_DAY] == $past(cnt[4]);
   endproperty
   a_refresh: assert property (p_refresh) else $error("visible bytes not refreshed after halt release"); // R3

   property p_load;
      $fell(ctl_write_reg) |-> cnt[2] == $past(vis_reg[2]) && cnt[7] == $past(vis_reg[7]);
   endproperty
   a_load: assert property (p_load) else $error("counters not loaded when write bit cleared"); // R5

   property p_osc_stop;
      // divider step taken on the setting edge itself is legal
      osc_stop_reg |-> !sec_tick ##1 $stable(div_reg);
   endproperty
   a_osc_stop: assert property (p_osc_stop) else $error("oscillator ran while stopped"); // R7

   property p_ft_toggle;
      tick |=> phase_reg != $past(phase_reg);
   endproperty
   a_ft_toggle: assert property (p_ft_toggle) else $error("test phase did not toggle on tick"); // R8

   property p_drive;
      !dq_oe_n |-> $past(!ce_f && we_f && !oe_f && !pf_f);
   endproperty
   a_drive: assert property (p_drive) else $error("data pins driven outside a read"); // R12

   property p_hold;
      addr_f != prev_addr_reg |=> $stable(dq_out_reg) [*2];
   endproperty
   a_hold: assert property (p_hold) else $error("output not held after address change"); // R13

   property p_commit;
      mem_we |-> $past(!ce_f && !we_f) && !pf_f;
   endproperty
   a_commit: assert property (p_commit) else $error("RAM written outside write mode"); // R14

   property p_block;
      pf_f |=> dq_oe_n && !wr_act_reg && !power_fail_out_n;
   endproperty
   a_block: assert property (p_block) else $error("access not blocked on power fail"); // R19

   property p_pfo;
      !pf_f ##1 !pf_f |-> power_fail_out_n;
   endproperty
   a_pfo: assert property (p_pfo) else $error("power-fail output low on good supply"); // R20
endmodule
`default_nettype wire

// File: design/nvr_time_counter.sv
/*
 Internal BCD timekeeping counters with calendar carry and leap years.
 Assumes sec_tick is a one-cycle pulse once per second and load has
 priority over counting.
*/
`timescale 1ns/1ps
`default_nettype none
module nvr_time_counter (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       sec_tick,
   input  wire logic       load,
   input  wire logic [7:0] ld_sec,
   input  wire logic [7:0] ld_min,
   input  wire logic [7:0] ld_hr,
   input  wire logic [7:0] ld_day,
   input  wire logic [7:0] ld_date,
   input  wire logic [7:0] ld_mon,
   input  wire logic [7:0] ld_year,
   output logic [7:0]      cnt_sec,
   output logic [7:0]      cnt_min,
   output logic [7:0]      cnt_hr,
   output logic [7:0]      cnt_day,
   output logic [7:0]      cnt_date,
   output logic [7:0]      cnt_mon,
   output logic [7:0]      cnt_year
);
   logic [7:0] sec_reg, min_reg, hr_reg, day_reg, date_reg, mon_reg, year_reg;
   logic [7:0] sec_next, min_next, hr_next, day_next, date_next, mon_next, year_next;

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction

   // valid through 2099, divisible-by-four years only
   function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
      logic leap;
      leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
      if (m == 8'h02) return leap ? 8'h29 : 8'h28;
      if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) return 8'h30;
      return 8'h31;
   endfunction

   always_comb begin
      {sec_next, min_next, hr_next, day_next} = {sec_reg, min_reg, hr_reg, day_reg};
      {date_next, mon_next, year_next} = {date_reg, mon_reg, year_reg};
      if (load) begin // R5
         sec_next = ld_sec & nvr_pkg::field_mask(3'h1);
         min_next = ld_min & nvr_pkg::field_mask(3'h2);
         hr_next = ld_hr & nvr_pkg::field_mask(3'h3);
         day_next = ld_day & nvr_pkg::field_mask(3'h4);
         date_next = ld_date & nvr_pkg::field_mask(3'h5);
         mon_next = ld_mon & nvr_pkg::field_mask(3'h6);
         year_next = ld_year;
      end else if (sec_tick) begin // R24
         sec_next = bcd_inc(sec_reg);
         if (sec_reg >= nvr_pkg::MAX_SEC) begin
            sec_next = nvr_pkg::BCD_ZERO;
            min_next = bcd_inc(min_reg);
            if (min_reg >= nvr_pkg::MAX_MIN) begin
               min_next = nvr_pkg::BCD_ZERO;
               hr_next = bcd_inc(hr_reg);
               if (hr_reg >= nvr_pkg::MAX_HR) begin
                  hr_next = nvr_pkg::BCD_ZERO;
                  day_next = (day_reg >= nvr_pkg::MAX_DAY) ? nvr_pkg::BCD_ONE : bcd_inc(day_reg);
                  date_next = bcd_inc(date_reg);
                  if (date_reg >= month_last(mon_reg, year_reg)) begin // R23
                     date_next = nvr_pkg::BCD_ONE;
                     mon_next = bcd_inc(mon_reg);
                     if (mon_reg >= nvr_pkg::MAX_MON) begin
                        mon_next = nvr_pkg::BCD_ONE;
                        year_next = (year_reg >= nvr_pkg::MAX_YEAR) ? nvr_pkg::BCD_ZERO : bcd_inc(year_reg);
                     end
                  end
               end
            end
         end
      end
   end

   // counters have no power-down path: they keep running on battery
   always_ff @(posedge clk) begin // R21
      if (!rst_n) begin
         {sec_reg, min_reg, hr_reg} <= {nvr_pkg::RST_SEC, nvr_pkg::RST_MIN, nvr_pkg::RST_HR};
         {day_reg, date_reg} <= {nvr_pkg::RST_DAY, nvr_pkg::RST_DATE};
         {mon_reg, year_reg} <= {nvr_pkg::RST_MON, nvr_pkg::RST_YEAR};
      end else begin
         {sec_reg, min_reg, hr_reg, day_reg} <= {sec_next, min_next, hr_next, day_next};
         {date_reg, mon_reg, year_reg} <= {date_next, mon_next, year_next};
      end
   end

   assign {cnt_sec, cnt_min, cnt_hr, cnt_day} = {sec_reg, min_reg, hr_reg, day_reg};
   assign {cnt_date, cnt_mon, cnt_year} = {date_reg, mon_reg, year_reg};

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_sec_wrap;
      sec_tick && !load && sec_reg == 8'h59 |=> sec_reg == 8'h00 && min_reg != $past(min_reg);
   endproperty
   a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap to 00"); // R24

   property p_month_end;
      sec_tick && !load && {sec_reg, min_reg, hr_reg} == 24'h595923 && date_reg == month_last(mon_reg, year_reg)
         |=> date_reg == 8'h01;
   endproperty
   a_month_end: assert property (p_month_end) else $error("date did not roll to 01 at month end"); // R23
endmodule
`default_nettype wire

// File: pkg/nvr_pkg.sv
/*
 Shared constants of the byte-wide RTC-SRAM: register addresses, bit
 positions, field masks, limits, reset values and timing counts.
 Assumes a 250 MHz core clock and a 15-bit byte address space.
*/
package nvr_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int SYNC_W = 27;
   localparam logic [14:0] ADDR_CTL = 15'h7FF8;
   localparam logic [14:0] ADDR_SEC = 15'h7FF9;
   localparam logic [14:0] ADDR_MIN = 15'h7FFA;
   localparam logic [14:0] ADDR_HR = 15'h7FFB;
   localparam logic [14:0] ADDR_DAY = 15'h7FFC;
   localparam logic [14:0] ADDR_DATE = 15'h7FFD;
   localparam logic [14:0] ADDR_MON = 15'h7FFE;
   localparam logic [14:0] ADDR_YEAR = 15'h7FFF;
   localparam int IDX_SEC = 1;
   localparam int IDX_DAY = 4;
   localparam int CTL_WRITE_BIT = 7;
   localparam int CTL_READ_BIT = 6;
   localparam int SEC_OSC_BIT = 7;
   localparam int DAY_FT_BIT = 6;
   localparam logic [7:0] MAX_SEC = 8'h59;
   localparam logic [7:0] MAX_MIN = 8'h59;
   localparam logic [7:0] MAX_HR = 8'h23;
   localparam logic [7:0] MAX_DAY = 8'h07;
   localparam logic [7:0] MAX_MON = 8'h12;
   localparam logic [7:0] MAX_YEAR = 8'h99;
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
   localparam logic [7:0] RST_SEC = 8'h00;
   localparam logic [7:0] RST_MIN = 8'h00;
   localparam logic [7:0] RST_HR = 8'h00;
   localparam logic [7:0] RST_DAY = 8'h01;
   localparam logic [7:0] RST_DATE = 8'h01;
   localparam logic [7:0] RST_MON = 8'h01;
   localparam logic [7:0] RST_YEAR = 8'h00;
   // {supply low, ce_n, oe_n, we_n, addr, data}: strobes idle high
   localparam logic [26:0] SYNC_RST = {1'b0, 3'h7, 15'h0000, 8'h00};
   localparam int CLK_HZ = 250_000_000;
   localparam int CLK_PERIOD_NS = 4;
   // two toggles per 512 Hz period
   localparam int TICK_HZ = 1024;
   localparam int OUT_HOLD_NS = 5;
   localparam int OUT_HOLD_CYC = (OUT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   function automatic logic [7:0] field_mask(input logic [2:0] idx);
      logic [7:0] m;
      m = 8'hFF;
      unique case (idx)
         3'h1: m = 8'h7F;
         3'h2: m = 8'h7F;
         3'h3: m = 8'h3F;
         3'h4: m = 8'h07;
         3'h5: m = 8'h3F;
         3'h6: m = 8'h1F;
         3'h7: m = 8'hFF;
         3'h0: m = 8'h00;
      endcase
      return m;
   endfunction
endpackage

// File: sim/nvr_host_model.sv
/*
 Host bus master model: drives chip select, strobes, address and data
 on falling clock edges. Assumes the device samples on rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module nvr_host_model (
   input  wire logic        clk,
   input  wire logic [7:0]  dq_out,
   input  wire logic        dq_oe_n,
   output logic             ce_n,
   output logic             oe_n,
   output logic             we_n,
   output logic [14:0]      addr,
   output logic [7:0]       dq_in
);
   logic [7:0] h_data;
   // released bus shows the host value, inverted after each write and each close
   assign dq_in = dq_oe_n ? h_data : dq_out;
   initial begin
      ce_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      addr = 15'h0000;
      h_data = 8'h00;
   end
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      h_data = d;
      oe_n = 1'b1;
      ce_n = 1'b0;
      we_n = 1'b0;
      idle(6);
      we_n = 1'b1;
      ce_n = 1'b1;
      idle(6);
      h_data = ~h_data;
   endtask
   task automatic open_rd(input logic [14:0] a);
      @(negedge clk);
      addr = a;
      ce_n = 1'b0;
      oe_n = 1'b0;
      idle(10);
   endtask
   // device stops driving first, so no contention on the shared bus
   task automatic lower_we(input logic [7:0] d);
      h_data = d;
      we_n = 1'b0;
      idle(8);
   endtask
   task automatic close();
      ce_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      h_data = ~h_data;
      idle(6);
   endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
/*
 Self-checking bench for the clock SRAM: host model on the strobes,
 supply flag from the bench. Assumes a shortened tick of 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int TICK = 4;
   logic        clk;
   logic        rst_n;
   logic        supply_below_pf;
   logic        ce_n;
   logic        oe_n;
   logic        we_n;
   logic [14:0] addr;
   logic [7:0]  dq_in;
   logic [7:0]  dq_out;
   logic        dq_oe_n;
   logic        power_fail_out_n;
   logic [7:0]  rv;
   int          n_fail = 0;
   int          num_checks = 0;

   nvr_rtc_sram #(
      .TICK_CYCLES      (TICK)
   ) u_dut (
      .clk              (clk),
      .rst_n            (rst_n),
      .ce_n             (ce_n),
      .oe_n             (oe_n),
      .we_n             (we_n),
      .addr             (addr),
      .dq_in            (dq_in),
      .dq_out           (dq_out),
      .dq_oe_n          (dq_oe_n),
      .supply_below_pf  (supply_below_pf),
      .power_fail_out_n (power_fail_out_n)
   );
   nvr_host_model u_host (
      .clk     (clk),
      .dq_out  (dq_out),
      .dq_oe_n (dq_oe_n),
      .ce_n    (ce_n),
      .oe_n    (oe_n),
      .we_n    (we_n),
      .addr    (addr),
      .dq_in   (dq_in)
   );

   always #2 clk = ~clk;

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rchk(input string what, input logic [14:0] a, input logic [7:0] exp);
      u_host.open_rd(a);
      rv = dq_in;
      u_host.close();
      chk(what, rv, exp);
   endtask
   function automatic int bcd(input logic [7:0] v);
      return int'(v[6:4]) * 10 + int'(v[3:0]);
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic t_reset();
      chk("idle_oe", {7'h00, dq_oe_n}, 8'h01);
      chk("pf_idle", {7'h00, power_fail_out_n}, 8'h01);
      rchk("ctl", nvr_pkg::ADDR_CTL, 8'h00);
      rchk("year", nvr_pkg::ADDR_YEAR, nvr_pkg::RST_YEAR);
      rchk("month", nvr_pkg::ADDR_MON, nvr_pkg::RST_MON);
      rchk("date", nvr_pkg::ADDR_DATE, nvr_pkg::RST_DATE);
      rchk("day", nvr_pkg::ADDR_DAY, nvr_pkg::RST_DAY);
   endtask
   task automatic t_ram();
      u_host.wr(15'h0000, 8'hA5);
      u_host.wr(15'h7FF7, 8'h3C);
      rchk("ram_lo", 15'h0000, 8'hA5);
      rchk("ram_top", 15'h7FF7, 8'h3C);
      u_host.open_rd(15'h0000);
      chk("rd_drive", {7'h00, dq_oe_n}, 8'h00);
      u_host.addr = 15'h7FF7;
      // past the pin latency, still inside the hold window
      u_host.idle(6);
      chk("rd_hold", dq_out, 8'hA5);
      u_host.idle(3);
      chk("rd_new", dq_out, 8'h3C);
      u_host.lower_we(8'h77);
      chk("we_off", {7'h00, dq_oe_n}, 8'h01);
      u_host.close();
      rchk("ram_oe_wr", 15'h7FF7, 8'h77);
   endtask
   // one second carry from 23:59:59 on the 28th of February
   task automatic t_set(input logic [7:0] yr, input logic [7:0] e_date, input logic [7:0] e_mon);
      u_host.wr(nvr_pkg::ADDR_CTL, 8'h80);
      rchk("ctl_w", nvr_pkg::ADDR_CTL, 8'h80);
      u_host.wr(nvr_pkg::ADDR_SEC, 8'h59);
      u_host.wr(nvr_pkg::ADDR_MIN, 8'h59);
      u_host.wr(nvr_pkg::ADDR_HR, 8'h23);
      u_host.wr(nvr_pkg::ADDR_DAY, 8'h07);
      u_host.wr(nvr_pkg::ADDR_DATE, 8'h28);
      u_host.wr(nvr_pkg::ADDR_MON, 8'h02);
      u_host.wr(nvr_pkg::ADDR_YEAR, yr);
      u_host.idle(4500);
      rchk("halt_w", nvr_pkg::ADDR_SEC, 8'h59);
      u_host.wr(nvr_pkg::ADDR_CTL, 8'h00);
      // more than one second, less than two: exactly one carry
      u_host.idle(4200);
      rchk("sec", nvr_pkg::ADDR_SEC, 8'h00);
      rchk("min", nvr_pkg::ADDR_MIN, 8'h00);
      rchk("hr", nvr_pkg::ADDR_HR, 8'h00);
      rchk("wday", nvr_pkg::ADDR_DAY, 8'h01);
      rchk("mday", nvr_pkg::ADDR_DATE, e_date);
      rchk("mon", nvr_pkg::ADDR_MON, e_mon);
      rchk("yr", nvr_pkg::ADDR_YEAR, yr);
   endtask
   task automatic t_halt();
      logic [7:0] s0;
      logic [7:0] s1;
      int d;
      u_host.wr(nvr_pkg::ADDR_CTL, 8'h40);
      rchk("ctl_r", nvr_pkg::ADDR_CTL, 8'h40);
      s0 = rv;
      u_host.open_rd(nvr_pkg::ADDR_SEC);
      s0 = dq_in;
      u_host.close();
      u_host.idle(9000);
      rchk("halt_r", nvr_pkg::ADDR_SEC, s0);
      u_host.wr(nvr_pkg::ADDR_CTL, 8'h00);
      u_host.open_rd(nvr_pkg::ADDR_SEC);
      s1 = dq_in;
      u_host.close();
      d = bcd(s1) - bcd(s0);
      chk("resume", 8'(d >= 2 && d <= 3), 8'h01);
   endtask
   task automatic t_osc();
      logic [7:0] s0;
      u_host.wr(nvr_pkg::ADDR_SEC, 8'h80);
      u_host.open_rd(nvr_pkg::ADDR_SEC);
      s0 = dq_in;
      u_host.close();
      chk("osc_bit", s0 & 8'h80, 8'h80);
      u_host.idle(9000);
      rchk("osc_stop", nvr_pkg::ADDR_SEC, s0);
      u_host.wr(nvr_pkg::ADDR_SEC, 8'h00);
      u_host.idle(4200);
      u_host.open_rd(nvr_pkg::ADDR_SEC);
      rv = dq_in;
      u_host.close();
      chk("osc_run", 8'(rv == (s0 & 8'h7F)), 8'h00);
   endtask
   task automatic t_ft();
      logic prev;
      int n;
      u_host.wr(nvr_pkg::ADDR_DAY, 8'h40);
      u_host.open_rd(nvr_pkg::ADDR_SEC);
      prev = dq_in[0];
      n = 0;
      repeat (800) begin
         @(negedge clk);
         if (dq_in[0] !== prev) n++;
         prev = dq_in[0];
      end
      u_host.close();
      chk("ft_toggles", 8'(n >= 800 / TICK - 1 && n <= 800 / TICK + 1), 8'h01);
      u_host.wr(nvr_pkg::ADDR_DAY, 8'h00);
   endtask
   task automatic t_pf();
      int k;
      u_host.wr(15'h0010, 8'h11);
      supply_below_pf = 1'b1;
      u_host.idle(8);
      chk("pf_low", {7'h00, power_fail_out_n}, 8'h00);
      u_host.wr(15'h0010, 8'hEE);
      u_host.open_rd(15'h0010);
      chk("pf_no_drive", {7'h00, dq_oe_n}, 8'h01);
      u_host.close();
      supply_below_pf = 1'b0;
      k = 0;
      while (power_fail_out_n !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      chk("pf_release", {7'h00, power_fail_out_n}, 8'h01);
      rchk("pf_keep", 15'h0010, 8'h11);
   endtask

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      supply_below_pf = 1'b0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      u_host.idle(4);
      t_reset();
      t_ram();
      t_set(8'h23, 8'h01, 8'h03);
      t_set(8'h24, 8'h29, 8'h02);
      t_halt();
      t_osc();
      t_ft();
      t_pf();
      give_verdict();
   end
endmodule
`default_nettype wire
